// file: hdl/pdc_map.svh
// register map, bit positions, reset values and divider counts
`ifndef PDC_MAP_SVH
`define PDC_MAP_SVH

// ----------------------------------------------------------------------
// bus geometry and register offsets
// ----------------------------------------------------------------------
`define PDC_ADDR_W 8
`define PDC_OFS_MODE_CLOCK 8'h00
`define PDC_OFS_STANDBY 8'h04
`define PDC_OFS_AUX 8'h08
`define PDC_RESP_OKAY 2'h0
`define PDC_RESP_SLVERR 2'h2

// ----------------------------------------------------------------------
// power_mode_clock_control fields
// ----------------------------------------------------------------------
`define PDC_BIT_SLEEP_SEL 7
`define PDC_BIT_DIRECT 5
`define PDC_DIV_HI 4
`define PDC_DIV_LO 2
`define PDC_MODE_CLOCK_MASK 8'hBC

// ----------------------------------------------------------------------
// peripheral_standby_control fields
// ----------------------------------------------------------------------
`define PDC_BIT_SERIAL 5
`define PDC_BIT_CONV 4
`define PDC_BIT_WDT 3
`define PDC_BIT_TW 2
`define PDC_BIT_TV 1
`define PDC_STANDBY_MASK 8'h3E

// ----------------------------------------------------------------------
// auxiliary control and status fields
// ----------------------------------------------------------------------
`define PDC_BIT_STBY_SEL 0
`define PDC_BIT_WDT_OSC 1
`define PDC_AUX_MASK 2'h3
`define PDC_AUX_MODE_LO 4
`define PDC_AUX_MODE_HI 5
`define PDC_AUX_DIV_LO 8
`define PDC_AUX_DIV_HI 10

// ----------------------------------------------------------------------
// reset values and divider terminal counts
// ----------------------------------------------------------------------
`define PDC_REG_RESET 8'h00
`define PDC_AUX_RESET 2'h0
`define PDC_DIV_CODE_RESET 3'h0
`define PDC_DIV_W 6
`define PDC_CODE_DIV8 3'h4
`define PDC_CODE_DIV16 3'h5
`define PDC_CODE_DIV32 3'h6
`define PDC_CODE_DIV64 3'h7
`define PDC_TC_DIV1 6'h00
`define PDC_TC_DIV8 6'h07
`define PDC_TC_DIV16 6'h0F
`define PDC_TC_DIV32 6'h1F
`define PDC_TC_DIV64 6'h3F

`endif

// file: hdl/pdc_pkg.sv
// types shared by the power-down clock select block
package pdc_pkg;
  `include "pdc_map.svh"

  // --------------------------------------------------------------------
  // operating modes
  // --------------------------------------------------------------------
  typedef enum logic [1:0]
  {
    pdc_active = 2'b00,
    pdc_sleep = 2'b01,
    pdc_subsleep = 2'b10,
    pdc_standby = 2'b11
  } pdc_mode_type;

  // --------------------------------------------------------------------
  // register bus carriers
  // --------------------------------------------------------------------
  typedef struct packed {
    logic awvalid;
    logic [`PDC_ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [`PDC_ADDR_W-1:0] araddr;
    logic rready;
  } pdc_axi_req_type;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } pdc_axi_rsp_type;

  // --------------------------------------------------------------------
  // module state records
  // --------------------------------------------------------------------
  typedef struct packed {
    logic [2:0] code;
    logic [2:0] pend_code;
    logic pend;
    logic [`PDC_DIV_W-1:0] cnt;
    logic tick;
  } pdc_div_state_type;

  typedef struct packed {
    logic en;
  } pdc_gate_state_type;

  typedef struct packed {
    logic [7:0] mode_clock;
    logic [7:0] standby;
    logic [1:0] aux;
    pdc_mode_type mode;
    logic div_apply;
    logic periph_reset;
    logic aw_held;
    logic [`PDC_ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [7:0] w_data;
    logic w_strb0;
    pdc_axi_rsp_type rsp;
  } pdc_top_state_type;
endpackage

// file: hdl/pdc_clk_div.sv
// oscillator divider producing the system clock enable pulse
`timescale 1ns/1ps
`include "pdc_map.svh"
module pdc_clk_div
  import pdc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [2:0] ratio_code,
  input wire logic apply,
  output logic tick,
  output logic [2:0] active_code
);
  pdc_div_state_type s;
  pdc_div_state_type next_s;

  function automatic logic [`PDC_DIV_W-1:0] term_count(input logic [2:0] c);
    logic [`PDC_DIV_W-1:0] t;
    t = `PDC_TC_DIV1;
    case (c)
      `PDC_CODE_DIV8: t = `PDC_TC_DIV8;
      `PDC_CODE_DIV16: t = `PDC_TC_DIV16;
      `PDC_CODE_DIV32: t = `PDC_TC_DIV32;
      `PDC_CODE_DIV64: t = `PDC_TC_DIV64;
      default: t = `PDC_TC_DIV1;
    endcase
    return t;
  endfunction

  always_comb
  begin
    next_s = s;
    next_s.tick = (s.cnt == term_count(s.code));
    if (next_s.tick)
    begin
      next_s.cnt = '0;
      // ratio swaps only at a period boundary: no short pulse
      if (s.pend)
      begin
        next_s.code = s.pend_code;
        next_s.pend = 1'b0;
      end
    end
    else
    begin
      next_s.cnt = s.cnt + `PDC_DIV_W'(1);
    end
    if (apply)
    begin
      next_s.pend = 1'b1;
      next_s.pend_code = ratio_code;
    end
    if (!rst_n)
    begin
      next_s = '0;
      next_s.code = `PDC_DIV_CODE_RESET;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    s <= next_s;
  end

  assign tick = s.tick;
  assign active_code = s.code;
endmodule

// file: hdl/pdc_clk_gate.sv
// per-consumer clock enable gate with module standby
`timescale 1ns/1ps
module pdc_clk_gate
  import pdc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic run,
  input wire logic standby,
  input wire logic keep,
  output logic en
);
  pdc_gate_state_type s;
  pdc_gate_state_type next_s;

  always_comb
  begin
    next_s.en = tick & run & (~standby | keep);
    if (!rst_n)
    begin
      next_s = '0;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    s <= next_s;
  end

  assign en = s.en;
endmodule

// file: hdl/pdc_power_down_clock_select.sv
// power-down mode select, clock divide and module standby control
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
`timescale 1ns/1ps
`include "pdc_map.svh"
module pdc_power_down_clock_select
  import pdc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire pdc_axi_req_type axi_req,
  output pdc_axi_rsp_type axi_rsp,
  input wire logic sleep_req,
  input wire logic wake_req,
  output pdc_mode_type power_mode,
  output logic periph_reset,
  output logic cpu_clk_en,
  output logic serial_clk_en,
  output logic conv_clk_en,
  output logic wdt_clk_en,
  output logic tw_clk_en,
  output logic tv_clk_en
);
  pdc_top_state_type s;
  pdc_top_state_type next_s;
  logic sys_tick;
  logic [2:0] applied_code;
  logic cpu_run;
  logic periph_run;
  logic wdt_run;

  // ----------------------------------------------------------------------
  // register read mux
  // ----------------------------------------------------------------------
  function automatic logic [31:0] read_word(input logic [`PDC_ADDR_W-1:0] a,
                                            input pdc_top_state_type st,
                                            input logic [2:0] code);
    logic [31:0] d;
    d = '0;
    case (a)
      `PDC_OFS_MODE_CLOCK: d[7:0] = st.mode_clock & `PDC_MODE_CLOCK_MASK;
      `PDC_OFS_STANDBY: d[7:0] = st.standby & `PDC_STANDBY_MASK;
      `PDC_OFS_AUX:
      begin
        d[1:0] = st.aux;
        d[`PDC_AUX_MODE_HI:`PDC_AUX_MODE_LO] = st.mode;
        d[`PDC_AUX_DIV_HI:`PDC_AUX_DIV_LO] = code;
      end
      default: d = '0;
    endcase
    return d;
  endfunction

  function automatic logic addr_mapped(input logic [`PDC_ADDR_W-1:0] a);
    return (a == `PDC_OFS_MODE_CLOCK) || (a == `PDC_OFS_STANDBY) ||
           (a == `PDC_OFS_AUX);
  endfunction

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    next_s = s;
    next_s.div_apply = 1'b0;

    // write address and data are taken independently
    if (axi_req.awvalid && s.rsp.awready)
    begin
      next_s.aw_held = 1'b1;
      next_s.aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && s.rsp.wready)
    begin
      next_s.w_held = 1'b1;
      next_s.w_data = axi_req.wdata[7:0];
      next_s.w_strb0 = axi_req.wstrb[0];
    end
    if (s.rsp.bvalid && axi_req.bready)
    begin
      next_s.rsp.bvalid = 1'b0;
    end

    // commit once both halves are in; response the cycle after
    if (s.aw_held && s.w_held && !s.rsp.bvalid)
    begin
      next_s.aw_held = 1'b0;
      next_s.w_held = 1'b0;
      next_s.rsp.bvalid = 1'b1;
      next_s.rsp.bresp = addr_mapped(s.aw_addr) ? `PDC_RESP_OKAY :
                         `PDC_RESP_SLVERR;
      if (s.w_strb0)
      begin
        // divider field only stored here; the divider sees it on sleep
        case (s.aw_addr)
          `PDC_OFS_MODE_CLOCK:
            next_s.mode_clock = s.w_data & `PDC_MODE_CLOCK_MASK;
          `PDC_OFS_STANDBY:
            next_s.standby = s.w_data & `PDC_STANDBY_MASK;
          `PDC_OFS_AUX:
            next_s.aux = s.w_data[1:0] & `PDC_AUX_MASK;
          default:
            next_s.aux = s.aux;
        endcase
      end
    end

    // read channel: one read in flight, answered the cycle after
    if (s.rsp.rvalid && axi_req.rready)
    begin
      next_s.rsp.rvalid = 1'b0;
    end
    if (axi_req.arvalid && s.rsp.arready)
    begin
      next_s.rsp.rvalid = 1'b1;
      next_s.rsp.rdata = read_word(axi_req.araddr, s, applied_code);
      next_s.rsp.rresp = addr_mapped(axi_req.araddr) ? `PDC_RESP_OKAY :
                         `PDC_RESP_SLVERR;
    end

    // ready flags are registered so the bus outputs come from flops
    next_s.rsp.awready = !next_s.aw_held && !next_s.rsp.bvalid;
    next_s.rsp.wready = !next_s.w_held && !next_s.rsp.bvalid;
    next_s.rsp.arready = !next_s.rsp.rvalid;

    // mode sequencing on the sleep instruction
    unique case (s.mode)
      pdc_active:
      begin
        if (sleep_req)
        begin
          // any sleep instruction loads the stored divide ratio
          next_s.div_apply = 1'b1;
          if (s.mode_clock[`PDC_BIT_DIRECT] &&
              !s.mode_clock[`PDC_BIT_SLEEP_SEL])
          begin
            next_s.mode = pdc_active;
          end
          else if (s.aux[`PDC_BIT_STBY_SEL])
          begin
            next_s.mode = pdc_standby;
          end
          else if (s.mode_clock[`PDC_BIT_SLEEP_SEL])
          begin
            next_s.mode = pdc_subsleep;
          end
          else
          begin
            next_s.mode = pdc_sleep;
          end
        end
      end
      pdc_sleep, pdc_subsleep, pdc_standby:
      begin
        if (wake_req)
        begin
          next_s.mode = pdc_active;
        end
      end
    endcase

    // timer V, serial and converter are held reset in subsleep and standby
    next_s.periph_reset = (next_s.mode == pdc_subsleep) ||
                          (next_s.mode == pdc_standby);

    if (!rst_n)
    begin
      next_s = '0;
      next_s.mode_clock = `PDC_REG_RESET;
      next_s.standby = `PDC_REG_RESET;
      next_s.aux = `PDC_AUX_RESET;
      next_s.mode = pdc_active;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    s <= next_s;
  end

  // ----------------------------------------------------------------------
  // system clock divider
  // ----------------------------------------------------------------------
  pdc_clk_div u_div
  (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .ratio_code(s.mode_clock[`PDC_DIV_HI:`PDC_DIV_LO]),
    .apply(s.div_apply),
    .tick(sys_tick),
    .active_code(applied_code)
  );

  // ----------------------------------------------------------------------
  // clock enables per consumer
  // ----------------------------------------------------------------------
  // oscillator halts in subsleep and standby, so peripherals stop there
  assign cpu_run = (s.mode == pdc_active);
  assign periph_run = (s.mode == pdc_active) || (s.mode == pdc_sleep);
  // watchdog on its own oscillator ignores both halt sources
  assign wdt_run = periph_run || s.aux[`PDC_BIT_WDT_OSC];

  pdc_clk_gate u_gate_cpu
  (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .tick(sys_tick),
    .run(cpu_run),
    .standby(1'b0),
    .keep(1'b0),
    .en(cpu_clk_en)
  );

  pdc_clk_gate u_gate_serial
  (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .tick(sys_tick),
    .run(periph_run),
    .standby(s.standby[`PDC_BIT_SERIAL]),
    .keep(1'b0),
    .en(serial_clk_en)
  );

  pdc_clk_gate u_gate_conv
  (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .tick(sys_tick),
    .run(periph_run),
    .standby(s.standby[`PDC_BIT_CONV]),
    .keep(1'b0),
    .en(conv_clk_en)
  );

  pdc_clk_gate u_gate_wdt
  (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .tick(sys_tick),
    .run(wdt_run),
    .standby(s.standby[`PDC_BIT_WDT]),
    .keep(s.aux[`PDC_BIT_WDT_OSC]),
    .en(wdt_clk_en)
  );

  pdc_clk_gate u_gate_tw
  (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .tick(sys_tick),
    .run(periph_run),
    .standby(s.standby[`PDC_BIT_TW]),
    .keep(1'b0),
    .en(tw_clk_en)
  );

  pdc_clk_gate u_gate_tv
  (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .tick(sys_tick),
    .run(periph_run),
    .standby(s.standby[`PDC_BIT_TV]),
    .keep(1'b0),
    .en(tv_clk_en)
  );

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign axi_rsp = s.rsp;
  assign power_mode = s.mode;
  assign periph_reset = s.periph_reset;
endmodule

// file: dv/pdc_check_sva.sv
// port assertions for the power-down clock select block
`timescale 1ns/1ps
module pdc_check
  import pdc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire pdc_axi_req_type axi_req,
  input wire pdc_axi_rsp_type axi_rsp,
  input wire logic sleep_req,
  input wire logic wake_req,
  input wire pdc_mode_type power_mode,
  input wire logic periph_reset,
  input wire logic cpu_clk_en,
  input wire logic serial_clk_en,
  input wire logic conv_clk_en,
  input wire logic wdt_clk_en,
  input wire logic tw_clk_en,
  input wire logic tv_clk_en
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // ----
  // mode control
  // ----
  wire logic deep = power_mode inside {pdc_subsleep, pdc_standby};
  property p_mode_hold;
    power_mode == pdc_active && !sleep_req |=> power_mode == pdc_active;
  endproperty
  a_mode_hold: assert property (p_mode_hold)
    else $error("mode left active without sleep");
  property p_wake;
    power_mode != pdc_active && wake_req |=> power_mode == pdc_active;
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake did not return to active");
  property p_idle_hold;
    power_mode == pdc_sleep && !wake_req |=> power_mode == pdc_sleep;
  endproperty
  a_idle_hold: assert property (p_idle_hold)
    else $error("sleep mode left without wake");
  // enable is one flop late; the check waits three halted cycles, allowing two to settle
  property p_cpu_halt;
    (power_mode != pdc_active) [*3] |-> !cpu_clk_en;
  endproperty
  a_cpu_halt: assert property (p_cpu_halt)
    else $error("cpu clock while halted");
  property p_deep_off;
    deep [*3] |-> !(serial_clk_en | conv_clk_en | tw_clk_en | tv_clk_en);
  endproperty
  a_deep_off: assert property (p_deep_off)
    else $error("peripheral clock in deep halt");
  property p_preset;
    $stable(power_mode) |-> periph_reset == deep;
  endproperty
  a_preset: assert property (p_preset)
    else $error("peripheral reset disagrees with mode");
  // ----
  // register bus
  // ----
  property p_read_ans;
    axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid;
  endproperty
  a_read_ans: assert property (p_read_ans)
    else $error("read not answered next cycle");
  property p_write_ans;
    axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready
      |-> ##[1:2] axi_rsp.bvalid;
  endproperty
  a_write_ans: assert property (p_write_ans)
    else $error("write not answered in time");
  property p_rd_zero;
    axi_rsp.rvalid |-> axi_rsp.rdata[31:11] == 21'h0;
  endproperty
  a_rd_zero: assert property (p_rd_zero)
    else $error("upper read bits not zero");
  c_sleep: cover property (power_mode == pdc_sleep);
  c_subsleep: cover property (power_mode == pdc_subsleep);
  c_standby: cover property (power_mode == pdc_standby);
endmodule

bind pdc_power_down_clock_select pdc_check pdc_check_inst (.ref_clk,
  .rst_n, .axi_req, .axi_rsp, .sleep_req, .wake_req, .power_mode,
  .periph_reset, .cpu_clk_en, .serial_clk_en, .conv_clk_en, .wdt_clk_en,
  .tw_clk_en, .tv_clk_en);

// file: dv/test_power_down_clock_select.sv
// self-checking bench for the power-down clock select block
`timescale 1ns/1ps
module test_power_down_clock_select
  import pdc_pkg::*;
;
  logic ref_clk;
  logic rst_n;
  pdc_axi_req_type req;
  pdc_axi_rsp_type rsp;
  logic sleep_req;
  logic wake_req;
  pdc_mode_type power_mode;
  logic periph_reset, cpu, ser, conv, wdt, tw, tv;
  wire logic [5:0] en_all = {ser, conv, wdt, tw, tv, cpu};
  int bad_count = 0;
  int comparisons = 0;
  int n;
  int p;
  int e;
  logic [5:0] s;
  pdc_mode_type md [4] = '{pdc_sleep, pdc_subsleep, pdc_standby,
    pdc_standby};

  pdc_power_down_clock_select pdc_power_down_clock_select_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .axi_req(req), .axi_rsp(rsp),
    .sleep_req(sleep_req), .wake_req(wake_req), .power_mode(power_mode),
    .periph_reset(periph_reset), .cpu_clk_en(cpu), .serial_clk_en(ser),
    .conv_clk_en(conv), .wdt_clk_en(wdt), .tw_clk_en(tw),
    .tv_clk_en(tv));

  initial
  begin
    ref_clk = 1'h0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // ----
  // reporting
  // ----
  task automatic wrap_up();
    $display("counts: %0d compared, %0d mismatched", comparisons,
      bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic hang();
    bad_count++;
    $display("unexpected at %0t: no answer", $time);
    wrap_up();
  endtask

  // ----
  // bus and pin drivers
  // ----
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
    input logic [1:0] er);
    logic aw;
    logic w;
    aw = 1'h0;
    w = 1'h0;
    n = 0;
    @(posedge ref_clk);
    req <= '{1'h1, a, 1'h1, {24'h0, d}, 4'hF, 1'h1, 1'h0, 8'h00, 1'h0};
    do
    begin
      @(posedge ref_clk);
      aw = aw | rsp.awready;
      w = w | rsp.wready;
      req.awvalid <= !aw;
      req.wvalid <= !w;
    end
    while (!(aw && w) && n++ < 40);
    n = 0;
    while (!rsp.bvalid && n++ < 40)
      @(posedge ref_clk);
    if (n > 40)
      hang();
    chk(rsp.bresp, er);
    req.bready <= 1'h0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp,
    input logic [1:0] er);
    n = 0;
    @(posedge ref_clk);
    req <= '{1'h0, 8'h00, 1'h0, 32'h0, 4'h0, 1'h0, 1'h1, a, 1'h1};
    do @(posedge ref_clk); while (!rsp.arready && n++ < 40);
    req.arvalid <= 1'h0;
    do @(posedge ref_clk); while (!rsp.rvalid && n++ < 40);
    if (n > 40)
      hang();
    chk(rsp.rdata, exp);
    chk(rsp.rresp, er);
    req.rready <= 1'h0;
  endtask

  // window spans the slowest divide period: a pending ratio swaps late
  task automatic en_seen();
    s = 6'h00;
    repeat (140)
    begin
      @(posedge ref_clk);
      s = s | en_all;
    end
  endtask

  // cycles between two cpu clock enables
  task automatic per();
    n = 0;
    do @(posedge ref_clk); while (!cpu && n++ < 200);
    p = 0;
    do
    begin
      @(posedge ref_clk);
      p++;
    end
    while (!cpu && p < 200);
    if (n > 200 || p >= 200)
      hang();
  endtask

  task automatic pulse(input logic wake);
    @(posedge ref_clk);
    if (wake)
      wake_req <= 1'h1;
    else
      sleep_req <= 1'h1;
    @(posedge ref_clk);
    wake_req <= 1'h0;
    sleep_req <= 1'h0;
    repeat (6) @(posedge ref_clk);
  endtask

  // ----
  // main sequence
  // ----
  initial
  begin
    req = '0;
    sleep_req = 1'h0;
    wake_req = 1'h0;
    rst_n = 1'h0;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'h1;
    rdc(8'h00, 32'h0, 2'h0);
    rdc(8'h04, 32'h0, 2'h0);
    wr(8'h00, 8'hFF, 2'h0);
    rdc(8'h00, 32'hBC, 2'h0);
    wr(8'h04, 8'hFF, 2'h0);
    rdc(8'h04, 32'h3E, 2'h0);
    wr(8'h0C, 8'hFF, 2'h2);
    rdc(8'h0C, 32'h0, 2'h2);
    wr(8'h00, 8'h00, 2'h0);
    $display("registers test done");
    for (int i = 1; i < 6; i++)
    begin
      wr(8'h04, 8'h01 << i, 2'h0);
      en_seen();
      chk(s, 6'h3F & ~(6'h01 << i));
    end
    wr(8'h04, 8'h08, 2'h0);
    wr(8'h08, 8'h02, 2'h0);
    en_seen();
    chk(s, 6'h3F);
    wr(8'h08, 8'h00, 2'h0);
    wr(8'h04, 8'h00, 2'h0);
    en_seen();
    chk(s, 6'h3F);
    $display("standby test done");
    e = 1;
    for (int c = 4; c < 8; c++)
    begin
      wr(8'h00, 8'(c << 2) | 8'h20, 2'h0);
      per();
      chk(p, e);
      pulse(1'h0);
      chk(power_mode, pdc_active);
      per();
      per();
      e = 8 << (c - 4);
      chk(p, e);
      rdc(8'h08, c << 8, 2'h0);
    end
    $display("divider test done");
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h08, 8'(i >> 1), 2'h0);
      wr(8'h00, 8'(i & 1) << 7, 2'h0);
      pulse(1'h0);
      chk(power_mode, md[i]);
      chk(periph_reset, i != 0);
      en_seen();
      chk(s, i == 0 ? 6'h3E : 6'h00);
      pulse(1'h1);
      chk(power_mode, pdc_active);
    end
    $display("mode test done");
    wrap_up();
  end
endmodule
